//--- core/srb_sfr_bank.sv
// Function
// - Carry flag follows carry or borrow of each arithmetic operation, else cleared; here a status word write in the same cycle wins and that update is lost.
// - Auxiliary carry follows carry into or borrow from upper nibble.
// - Two user flags in status word hold only what software writes.
// - Bank select field picks one of four eight-byte register banks.
// - Overflow flag follows carry, borrow or multiply/divide overflow, else cleared.
// - Parity flag is one when accumulator holds an odd number of ones.
// - Status word sits at 0xD0, carry in bit seven, parity in bit zero.
// - Reset loads every register with its listed reset value.
//
// Chosen here: the Avalon-MM register port.
`include "srb_params.svh"
`timescale 1ns/1ns
`default_nettype none
module srb_sfr_bank
   import srb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave, byte address in low byte of word index
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Arithmetic flag update from the execution unit
   input wire logic alu_update_i,
   input wire logic alu_carry_i,
   input wire logic alu_aux_carry_i,
   input wire logic alu_overflow_i,
   // Accumulator load from the execution unit
   input wire logic acc_load_i,
   input wire logic [7:0] acc_data_i,
   // Status outputs
   output logic [7:0] program_status_word_o,
   output logic [7:0] accumulator_o,
   output logic [4:0] bank_base_o,
   output logic [7:0] stack_pointer_o,
   output logic [7:0] tick_divider_o,
   output logic [7:0] port0_direction_o,
   output logic [7:0] port1_direction_o,
   // Read-only converter result inputs
   input wire logic [7:0] conv_high_i,
   input wire logic [7:0] conv_low_i
);

   // Table of registers decoded by address, index = position below
   // Adding a register means one line here and one in the reset table, same position
   localparam int NREG = 46;
   localparam logic [7:0] REG_ADDR [NREG] = '{
      `SRB_ADDR_SP, // 0 stack pointer
      `SRB_ADDR_DPL, // 1 data pointer low
      `SRB_ADDR_DPH, // 2 data pointer high
      `SRB_ADDR_ALT_DATA_POINTER_LOW, // 3 alternate data pointer low
      `SRB_ADDR_ALT_DATA_POINTER_HIGH, // 4 alternate data pointer high
      `SRB_ADDR_DSEL, // 5 data pointer select
      `SRB_ADDR_PWRC, // 6 power control
      `SRB_ADDR_TCTL, // 7 timer control
      `SRB_ADDR_TMODE, // 8 timer mode
      `SRB_ADDR_T0L, // 9 timer 0 low
      `SRB_ADDR_T1L, // 10 timer 1 low
      `SRB_ADDR_T0H, // 11 timer 0 high
      `SRB_ADDR_T1H, // 12 timer 1 high
      `SRB_ADDR_CKDIV, // 13 clock divide config
      `SRB_ADDR_SFCTL, // 14 special function control
      `SRB_ADDR_PORT1, // 15 port 1 value
      `SRB_ADDR_P0DIR, // 16 port 0 direction
      `SRB_ADDR_P0ALT, // 17 port 0 alternate
      `SRB_ADDR_P1DIR, // 18 port 1 direction
      `SRB_ADDR_P1ALT, // 19 port 1 alternate
      `SRB_ADDR_SERC, // 20 serial control
      `SRB_ADDR_SERB, // 21 serial buffer
      `SRB_ADDR_RADIO, // 22 radio port
      `SRB_ADDR_CONVC, // 23 converter control
      `SRB_ADDR_CONVS, // 24 converter static config
      `SRB_ADDR_IEN, // 25 interrupt enable, read only
      `SRB_ADDR_PWMC, // 26 pulse width control
      `SRB_ADDR_PWMD, // 27 pulse width duty
      `SRB_ADDR_WRH, // 28 watchdog/clock data high
      `SRB_ADDR_WRL, // 29 watchdog/clock data low
      `SRB_ADDR_WRC, // 30 watchdog/clock access control
      `SRB_ADDR_RCAUSE, // 31 reset cause
      `SRB_ADDR_SPD, // 32 serial peripheral data
      `SRB_ADDR_SPR, // 33 serial peripheral route
      `SRB_ADDR_SPDIV, // 34 serial peripheral divider
      `SRB_ADDR_TICK, // 35 tick divider
      `SRB_ADDR_CKSTOP, // 36 clock stop control
      `SRB_ADDR_IPRI, // 37 interrupt priority
      `SRB_ADDR_T2C, // 38 timer 2 control
      `SRB_ADDR_T2RL, // 39 timer 2 reload low
      `SRB_ADDR_T2RH, // 40 timer 2 reload high
      `SRB_ADDR_T2L, // 41 timer 2 low
      `SRB_ADDR_T2H, // 42 timer 2 high
      `SRB_ADDR_EXTIC, // 43 external interrupt control
      `SRB_ADDR_ACCUM, // 44 accumulator
      `SRB_ADDR_STATUS // 45 status word
   };
   // Reset image, same order as the address table
   localparam logic [7:0] REG_RST [NREG] = '{
      `SRB_RST_SP, // 0
      `SRB_RST_ZERO, // 1
      `SRB_RST_ZERO, // 2
      `SRB_RST_ZERO, // 3
      `SRB_RST_ZERO, // 4
      `SRB_RST_ZERO, // 5
      `SRB_RST_PWRC, // 6
      `SRB_RST_ZERO, // 7
      `SRB_RST_ZERO, // 8
      `SRB_RST_ZERO, // 9
      `SRB_RST_ZERO, // 10
      `SRB_RST_ZERO, // 11
      `SRB_RST_ZERO, // 12
      `SRB_RST_CKDIV, // 13
      `SRB_RST_ZERO, // 14
      `SRB_RST_PORT, // 15
      `SRB_RST_PORT, // 16
      `SRB_RST_ZERO, // 17
      `SRB_RST_PORT, // 18
      `SRB_RST_ZERO, // 19
      `SRB_RST_ZERO, // 20
      `SRB_RST_ZERO, // 21
      `SRB_RST_RADIO, // 22
      `SRB_RST_CONVC, // 23
      `SRB_RST_CONVS, // 24
      `SRB_RST_ZERO, // 25
      `SRB_RST_ZERO, // 26
      `SRB_RST_ZERO, // 27
      `SRB_RST_ZERO, // 28
      `SRB_RST_ZERO, // 29
      `SRB_RST_ZERO, // 30
      `SRB_RST_RCAUSE, // 31
      `SRB_RST_ZERO, // 32
      `SRB_RST_ZERO, // 33
      `SRB_RST_ZERO, // 34
      `SRB_RST_TICK, // 35
      `SRB_RST_ZERO, // 36
      `SRB_RST_IPRI, // 37
      `SRB_RST_ZERO, // 38
      `SRB_RST_ZERO, // 39
      `SRB_RST_ZERO, // 40
      `SRB_RST_ZERO, // 41
      `SRB_RST_ZERO, // 42
      `SRB_RST_EXTIC, // 43
      `SRB_RST_ZERO, // 44
      `SRB_RST_ZERO // 45
   };
   // Index of registers the logic treats specially
   localparam int IDX_SP = 0;
   localparam int IDX_P0DIR = 16;
   localparam int IDX_P1DIR = 18;
   localparam int IDX_TICK = 35;
   localparam int IDX_IEN = 25;
   localparam int IDX_ACC = 44;
   localparam int IDX_PSW = 45;

   // Word index to byte address: only indexes 0..255 are mapped
   function automatic logic [7:0] sfr_of(input logic [9:0] a);
      sfr_of = a[7:0];
   endfunction

   srb_byte_t regs [NREG];
   srb_bus_state_t state_reg;
   logic [NREG-1:0] hit;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   logic wait_reg;
   logic [7:0] psw_out_reg;
   logic [4:0] bank_reg;

   // Address decode, one comparator per register
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_dec
         assign hit[g] = (avs_address_i[9:8] == 2'b00) && (sfr_of(avs_address_i) == REG_ADDR[g]);
      end
   endgenerate

   wire logic req = avs_read_i | avs_write_i;
   wire logic wr_lane = avs_byteenable_i[0];
   wire logic is_conv_h = (avs_address_i == {2'b00, `SRB_ADDR_CONVH});
   wire logic is_conv_l = (avs_address_i == {2'b00, `SRB_ADDR_CONVL});
   wire logic is_flags = (avs_address_i == {2'b00, `SRB_ADDR_ALUFLAGS});
   wire logic mapped = (|hit) | is_conv_h | is_conv_l | is_flags;
   wire logic take = req && (state_reg == SRB_IDLE);
   wire logic do_write = take && avs_write_i && wr_lane;

   // Parity tracks the accumulator continuously, never stored from a write
   wire logic acc_parity = ^regs[IDX_ACC];

   // Read mux
   srb_byte_t rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            rd_byte = regs[i];
         end
      end
      if (hit[IDX_PSW]) begin
         rd_byte = {regs[IDX_PSW][7:1], acc_parity};
      end
      if (is_conv_h) begin
         rd_byte = conv_high_i;
      end
      if (is_conv_l) begin
         rd_byte = conv_low_i;
      end
      if (is_flags) begin
         rd_byte = {5'h00, alu_carry_i, alu_aux_carry_i, alu_overflow_i};
      end
   end

   // Register storage; interrupt enable is read only, so writes skip it
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         if (g == IDX_PSW) begin : g_psw
            always_ff @(posedge clk_i or negedge rst_n_i) begin
               if (!rst_n_i) begin
                  regs[g] <= REG_RST[g];
               end else if (do_write && hit[g]) begin
                  regs[g] <= {avs_writedata_i[7:1], 1'b0};
               end else if (alu_update_i) begin
                  regs[g][`SRB_BIT_CY] <= alu_carry_i;
                  regs[g][`SRB_BIT_AC] <= alu_aux_carry_i;
                  regs[g][`SRB_BIT_OV] <= alu_overflow_i;
               end
            end
         end else if (g == IDX_ACC) begin : g_acc
            always_ff @(posedge clk_i or negedge rst_n_i) begin
               if (!rst_n_i) begin
                  regs[g] <= REG_RST[g];
               end else if (do_write && hit[g]) begin
                  regs[g] <= avs_writedata_i[7:0];
               end else if (acc_load_i) begin
                  regs[g] <= acc_data_i;
               end
            end
         end else begin : g_plain
            always_ff @(posedge clk_i or negedge rst_n_i) begin
               if (!rst_n_i) begin
                  regs[g] <= REG_RST[g];
               end else if (do_write && hit[g] && (g != IDX_IEN)) begin
                  regs[g] <= avs_writedata_i[7:0];
               end
            end
         end
      end
   endgenerate

   // Bus handshake: request taken in IDLE, answered one cycle later with waitrequest low
   srb_bus_state_t state_next;
   always_comb begin
      case (state_reg)
         SRB_IDLE: state_next = req ? SRB_ACK : SRB_IDLE;
         SRB_ACK: state_next = SRB_DONE;
         SRB_DONE: state_next = SRB_IDLE;
         default: state_next = SRB_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= SRB_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         resp_reg <= 2'b00;
      end else begin
         state_reg <= state_next;
         wait_reg <= ~take; // Low for exactly the cycle after the request was taken
         if (take) begin
            rdata_reg <= avs_read_i ? {24'h000000, rd_byte} : 32'h00000000;
            resp_reg <= mapped ? 2'b00 : 2'b11; // Unmapped answers DECODEERROR
         end
      end
   end

   // Status word and bank base, registered so outputs come from flip-flops
   wire logic [7:0] psw_view = {regs[IDX_PSW][7:1], acc_parity};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         psw_out_reg <= 8'h00;
         bank_reg <= 5'h00;
      end else begin
         psw_out_reg <= psw_view;
         bank_reg <= {regs[IDX_PSW][`SRB_BIT_BSH:`SRB_BIT_BSL], 3'b000};
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign avs_response_o = resp_reg;
   assign program_status_word_o = psw_out_reg;
   assign bank_base_o = bank_reg;
   assign accumulator_o = regs[IDX_ACC];
   assign stack_pointer_o = regs[IDX_SP];
   assign tick_divider_o = regs[IDX_TICK];
   assign port0_direction_o = regs[IDX_P0DIR];
   assign port1_direction_o = regs[IDX_P1DIR];
endmodule
`default_nettype wire

//--- core/srb_params.svh
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH
// Register offsets (special function addresses)
`define SRB_ADDR_SP 8'h81
`define SRB_ADDR_DPL 8'h82
`define SRB_ADDR_DPH 8'h83
`define SRB_ADDR_ALT_DATA_POINTER_LOW 8'h84
`define SRB_ADDR_ALT_DATA_POINTER_HIGH 8'h85
`define SRB_ADDR_DSEL 8'h86
`define SRB_ADDR_PWRC 8'h87
`define SRB_ADDR_TCTL 8'h88
`define SRB_ADDR_TMODE 8'h89
`define SRB_ADDR_T0L 8'h8A
`define SRB_ADDR_T1L 8'h8B
`define SRB_ADDR_T0H 8'h8C
`define SRB_ADDR_T1H 8'h8D
`define SRB_ADDR_CKDIV 8'h8E
`define SRB_ADDR_SFCTL 8'h8F
`define SRB_ADDR_PORT1 8'h90
`define SRB_ADDR_P0DIR 8'h94
`define SRB_ADDR_P0ALT 8'h95
`define SRB_ADDR_P1DIR 8'h96
`define SRB_ADDR_P1ALT 8'h97
`define SRB_ADDR_SERC 8'h98
`define SRB_ADDR_SERB 8'h99
`define SRB_ADDR_RADIO 8'hA0
`define SRB_ADDR_CONVC 8'hA1
`define SRB_ADDR_CONVH 8'hA2
`define SRB_ADDR_CONVL 8'hA3
`define SRB_ADDR_CONVS 8'hA4
`define SRB_ADDR_IEN 8'hA8
`define SRB_ADDR_PWMC 8'hA9
`define SRB_ADDR_PWMD 8'hAA
`define SRB_ADDR_WRH 8'hAB
`define SRB_ADDR_WRL 8'hAC
`define SRB_ADDR_WRC 8'hAD
`define SRB_ADDR_RCAUSE 8'hB1
`define SRB_ADDR_SPD 8'hB2
`define SRB_ADDR_SPR 8'hB3
`define SRB_ADDR_SPDIV 8'hB4
`define SRB_ADDR_TICK 8'hB5
`define SRB_ADDR_CKSTOP 8'hB6
`define SRB_ADDR_IPRI 8'hB8
`define SRB_ADDR_T2C 8'hC8
`define SRB_ADDR_T2RL 8'hCA
`define SRB_ADDR_T2RH 8'hCB
`define SRB_ADDR_T2L 8'hCC
`define SRB_ADDR_T2H 8'hCD
`define SRB_ADDR_STATUS 8'hD0
`define SRB_ADDR_EXTIC 8'hD8
`define SRB_ADDR_ACCUM 8'hE0
// Private register: arithmetic result flags from the core, read only
`define SRB_ADDR_ALUFLAGS 8'hF4
// Reset values that are not zero, then the common zero value
`define SRB_RST_SP 8'h07
`define SRB_RST_PWRC 8'h30
`define SRB_RST_CKDIV 8'h01
`define SRB_RST_PORT 8'hFF
`define SRB_RST_RADIO 8'h80
`define SRB_RST_CONVC 8'h80
`define SRB_RST_CONVS 8'h0A
`define SRB_RST_RCAUSE 8'h02
`define SRB_RST_TICK 8'h1D
`define SRB_RST_IPRI 8'h80
`define SRB_RST_EXTIC 8'h40
`define SRB_RST_ZERO 8'h00
// Status word bit positions
`define SRB_BIT_CY 7
`define SRB_BIT_AC 6
`define SRB_BIT_UFA 5
`define SRB_BIT_BSH 4
`define SRB_BIT_BSL 3
`define SRB_BIT_OV 2
`define SRB_BIT_UFB 1
`define SRB_BIT_PAR 0
// Bank size in bytes, as a shift
`define SRB_BANK_SHIFT 3
`endif

//--- core/srb_pkg.sv
`default_nettype none
package srb_pkg;
   typedef enum logic [2:0] {
      SRB_IDLE = 3'b001,
      SRB_ACK = 3'b010,
      SRB_DONE = 3'b100
   } srb_bus_state_t;
   typedef logic [7:0] srb_byte_t;
endpackage
`default_nettype wire

//--- testbench/srb_sfr_bank_props.sv
`timescale 1ns/1ns
`default_nettype none
module srb_sfr_bank_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic alu_update_i,
   input wire logic alu_carry_i,
   input wire logic alu_aux_carry_i,
   input wire logic alu_overflow_i,
   input wire logic [7:0] program_status_word_o,
   input wire logic [7:0] accumulator_o,
   input wire logic [4:0] bank_base_o,
   input wire logic [7:0] stack_pointer_o,
   input wire logic [7:0] tick_divider_o,
   input wire logic [7:0] port0_direction_o,
   input wire logic [7:0] port1_direction_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Answer cycle of a status word write; stable windows absorb the one-cycle output lag
   wire psw_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h0D0 && avs_byteenable_i[0];
   property p_carry; logic c;
      (alu_update_i && !avs_write_i, c = alu_carry_i) ##1 (!alu_update_i && !avs_write_i)[*2]
      |-> program_status_word_o[7] == c;
   endproperty
   property p_auxov; logic [1:0] f;
      (alu_update_i && !avs_write_i, f = {alu_aux_carry_i, alu_overflow_i}) ##1 (!alu_update_i && !avs_write_i)[*2]
      |-> {program_status_word_o[6], program_status_word_o[2]} == f;
   endproperty
   property p_user;
      !avs_write_i[*4] |-> $stable(program_status_word_o[5]) && $stable(program_status_word_o[1]);
   endproperty
   property p_parity;
      $stable(accumulator_o)[*3] |-> program_status_word_o[0] == ^accumulator_o;
   endproperty
   property p_bank;
      $stable(program_status_word_o)[*3] |-> bank_base_o == {program_status_word_o[4:3], 3'b000};
   endproperty
   property p_map;
      $stable(program_status_word_o)[*3] ##0 (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h0D0)
      |-> avs_readdata_o == {24'h000000, program_status_word_o};
   endproperty
   property p_reset;
      $rose(rst_n_i) |-> stack_pointer_o == 8'h07 && tick_divider_o == 8'h1D && port0_direction_o == 8'hFF
         && port1_direction_o == 8'hFF && program_status_word_o == 8'h00;
   endproperty
   property p_pswwr; logic [6:0] d;
      (psw_wr && !alu_update_i, d = avs_writedata_i[7:1]) ##1 !alu_update_i[*2] |-> program_status_word_o[7:1] == d;
   endproperty
   a_carry: assert property (p_carry) else $error("carry flag not loaded");
   a_auxov: assert property (p_auxov) else $error("aux or overflow flag not loaded");
   a_user: assert property (p_user) else $error("user flag changed without write");
   a_parity: assert property (p_parity) else $error("parity flag wrong");
   a_bank: assert property (p_bank) else $error("bank base wrong");
   a_map: assert property (p_map) else $error("status word read wrong");
   a_reset: assert property (p_reset) else $error("reset value wrong");
   a_pswwr: assert property (p_pswwr) else $error("status word write lost");
   c_alu: cover property (alu_update_i);
   c_pswwr: cover property (psw_wr);
   c_unmapped: cover property (!avs_waitrequest_o && avs_response_o == 2'b11);
endmodule
bind srb_sfr_bank srb_sfr_bank_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .avs_response_o(avs_response_o), .alu_update_i(alu_update_i), .alu_carry_i(alu_carry_i),
   .alu_aux_carry_i(alu_aux_carry_i), .alu_overflow_i(alu_overflow_i), .program_status_word_o(program_status_word_o),
   .accumulator_o(accumulator_o), .bank_base_o(bank_base_o), .stack_pointer_o(stack_pointer_o),
   .tick_divider_o(tick_divider_o), .port0_direction_o(port0_direction_o), .port1_direction_o(port1_direction_o));
`default_nettype wire

//--- testbench/srb_sfr_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module srb_sfr_bank_test;
   import srb_pkg::*;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
   logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, alu_up = 1'b0, acc_ld = 1'b0, wait_r;
   logic [9:0] addr = 10'h000;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic [2:0] alu_f = 3'h0, f;
   logic [1:0] resp;
   logic [4:0] bank;
   logic [33:0] e;
   srb_byte_t acc_d = 8'h00, conv_h = 8'h00, conv_l = 8'h00, program_status_word, acc, sp, tick, p0d, p1d, d, a;
   int n_fail = 0, checks_done = 0, cyc = 0, i;
   int seed = 32'h2DE37F5F;
   logic [33:0] exp_q[$];
   // Reset image of a sample of places, address in the upper byte
   localparam logic [15:0] RV [16] = '{16'h8107, 16'h8730, 16'h8E01, 16'h90FF, 16'h94FF, 16'h9500, 16'h96FF,
      16'hA080, 16'hA180, 16'hA40A, 16'hA800, 16'hB102, 16'hB51D, 16'hB880, 16'hD840, 16'hD000};
   srb_sfr_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
      .avs_response_o(resp), .alu_update_i(alu_up), .alu_carry_i(alu_f[2]), .alu_aux_carry_i(alu_f[1]),
      .alu_overflow_i(alu_f[0]), .acc_load_i(acc_ld), .acc_data_i(acc_d), .program_status_word_o(program_status_word),
      .accumulator_o(acc), .bank_base_o(bank), .stack_pointer_o(sp), .tick_divider_o(tick),
      .port0_direction_o(p0d), .port1_direction_o(p1d), .conv_high_i(conv_h), .conv_low_i(conv_l));
   always #25 clk_i = ~clk_i;
   task final_report;
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         final_report;
      end
   end
   // Answered reads are matched against the oldest note
   always @(posedge clk_i) if (rst_n_i && rd && wait_r === 1'b0) begin
      e = exp_q.pop_front();
      `CHK({resp, rdata}, e)
   end
   // One bus cycle; request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [9:0] ad, input srb_byte_t dt, input logic [33:0] ex);
      @(posedge clk_i);
      addr <= ad; wr <= w; rd <= !w; wdata <= {24'h000000, dt};
      if (!w) exp_q.push_back(ex);
      // Waitrequest is sampled at the rising edge itself, before the slave updates it
      do @(posedge clk_i); while (wait_r !== 1'b0);
      wr <= 1'b0; rd <= 1'b0;
   endtask
   // Execution unit: flag update and accumulator load in one pulse
   task hw(input logic [2:0] fl, input srb_byte_t ac);
      @(posedge clk_i);
      alu_up <= 1'b1; alu_f <= fl; acc_ld <= 1'b1; acc_d <= ac;
      @(posedge clk_i);
      alu_up <= 1'b0; acc_ld <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         bus(1'b1, 10'h081, d, 34'h0);
         bus(1'b0, 10'h081, 8'h00, {26'h0, d});
      end
      @(posedge clk_i);
      conv_h <= 8'($random(seed)); conv_l <= 8'($random(seed));
      // Read-only places keep their value; an out-of-map index must error
      bus(1'b1, 10'h0A8, 8'hFF, 34'h0);
      bus(1'b0, 10'h0A8, 8'h00, 34'h0);
      bus(1'b1, 10'h0A2, 8'h5A, 34'h0);
      bus(1'b0, 10'h0A2, 8'h00, {26'h0, conv_h});
      bus(1'b0, 10'h0A3, 8'h00, {26'h0, conv_l});
      bus(1'b0, 10'h0F0, 8'h00, 34'h300000000);
      bus(1'b0, 10'h3D0, 8'h00, 34'h300000000);
      $display("test access done");
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed)); a = 8'($random(seed)); f = 3'($random(seed));
         d[4:3] = i[1:0];
         bus(1'b1, 10'h0D0, d, 34'h0);
         hw(f, a);
         bus(1'b0, 10'h0D0, 8'h00, {26'h0, f[2], f[1], d[5:3], f[0], d[1], ^a});
         `CHK(bank, {d[4:3], 3'b000})
      end
      // Written parity bit is ignored; the accumulator decides it
      bus(1'b1, 10'h0E0, 8'h01, 34'h0);
      bus(1'b1, 10'h0D0, 8'h00, 34'h0);
      bus(1'b0, 10'h0D0, 8'h00, {26'h0, 8'h01});
      $display("test flags done");
      rst_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      `CHK({sp, tick, p0d, p1d}, 32'h071DFFFF)
      foreach (RV[i]) bus(1'b0, {2'b00, RV[i][15:8]}, 8'h00, {26'h0, RV[i][7:0]});
      $display("test reset done");
      final_report;
   end
endmodule
`default_nettype wire
